// *** rtl/cdm_top.sv ***
// Purpose: Machine-cycle divider, clock source control, data RAM map
// Assumes: All inputs synchronous to ref_clk_in
// Notes:   Ring oscillator arrives as a tick enable, not a clock
`include "cdm_regs.svh"

// Function
// - Low data moves go to on-chip RAM
// - Software enable bit gates on-chip data RAM
// - Data moves above top go to port bus
// - Data RAM separate from direct internal RAM
// - Divider codes: reserved, 4, 64, 1024
// - Reset runs at four clocks per cycle
// - Slow modes divide source by 64 or 1024
// - Only software writes enter slow mode
// - Ring source allowed, crystal amp may stop
// - Divider and source select are independent
// - Leave slow mode by software or switchback
// - New ratio applies one machine cycle later
// - Divided enable feeds all clocked functions outside idle
// - Slow ratio accepted only from four clocks
// - Idle keeps peripherals at crystal over four
// - Amp disable set only while ring selected
// - Crystal reselect needs stable crystal, amp on
// - Read-only crystal stable flag in status
// - Switchback restores four clocks on events
module cdm_top
    import cdm_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [9:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        ring_tick_in,
    input  wire logic        xtal_stable_in,
    input  wire logic        idle_in,
    input  wire logic        ext_irq_in,
    input  wire logic        ser_start_in,
    input  wire logic        tx_load_in,
    input  wire logic        xmove_req_in,
    input  wire logic        xmove_we_in,
    input  wire logic [15:0] xmove_addr_in,
    input  wire logic [7:0]  xmove_wdata_in,
    output logic      [7:0]  xmove_rdata_out,
    output logic             xmove_ack_out,
    output logic             ext_req_out,
    output logic             ext_we_out,
    output logic      [15:0] ext_addr_out,
    output logic      [7:0]  ext_wdata_out,
    output logic             mcycle_en_out,
    output logic             periph_en_out,
    output logic             xtal_amp_off_out,
    output logic             ring_mode_out
);

    // Source ticks per machine cycle, minus one
    function automatic logic [9:0] div_limit(input cdm_div_e d);
        unique case (d)
            CDM_DIV_64:   div_limit = `CDM_LIM_64;
            CDM_DIV_1024: div_limit = `CDM_LIM_1024;
            default:      div_limit = `CDM_LIM_4;
        endcase
    endfunction

    cdm_state_s s_q;      // Registered state
    cdm_state_s s_d;      // Next state
    logic [7:0] idx;      // Register index from byte address
    logic [7:0] wd;       // Low write data lane
    logic       wr_go;    // Write commits on the ack edge
    logic       pmr_wr;   // Power control write
    logic       ext_int_flag_and_clock_source_wr;  // Clock source write
    logic       sb_ev;    // Switchback event
    logic       src_tick; // One tick of the selected source
    logic       mc_tick;  // Machine cycle boundary
    logic       xhit;     // Data move hits on-chip RAM
    logic       div_ok;   // Divider write accepted
    cdm_div_e   wdiv;     // Divider code being written

    assign idx     = wb_adr_in[9:2];
    assign wd      = wb_dat_in[7:0];
    assign wr_go   = wb_cyc_in & wb_stb_in & wb_we_in & s_q.ack & wb_sel_in[0];
    assign pmr_wr  = wr_go && (idx == `CDM_IDX_PMR);
    assign ext_int_flag_and_clock_source_wr = wr_go && (idx == `CDM_IDX_EXT_INT_FLAG_AND_CLOCK_SOURCE);
    assign wdiv    = cdm_div_e'(wd[`CDM_DIV_HI:`CDM_DIV_LO]);
    // Slow codes only from a settled four-clock rate
    assign div_ok  = (wdiv == CDM_DIV_4) ||
                     ((wdiv != CDM_DIV_RSVD) &&
                      (s_q.div_act == CDM_DIV_4) &&
                      (s_q.div_new == CDM_DIV_4));
    assign sb_ev   = s_q.auto_fast_return_enable & (ext_irq_in | ser_start_in | tx_load_in);
    // Ring runs only while crystal is deselected
    assign src_tick = s_q.src_xtal | ring_tick_in;
    assign mc_tick  = src_tick && (s_q.cnt == div_limit(s_q.div_act));
    assign xhit     = s_q.dme && (xmove_addr_in <= `CDM_RAM_TOP);

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // Bus answer one cycle after the request, dropped after one cycle
        s_d.ack  = wb_cyc_in & wb_stb_in & ~s_q.ack;
        s_d.rdat = 32'h0000_0000;
        unique case (idx)
            `CDM_IDX_EXT_INT_FLAG_AND_CLOCK_SOURCE: begin
                s_d.rdat[`CDM_SRC_BIT]  = s_q.src_xtal;
                s_d.rdat[`CDM_RGMD_BIT] = ~s_q.src_xtal;
            end
            `CDM_IDX_PMR: begin
                s_d.rdat[`CDM_DIV_HI:`CDM_DIV_LO] = s_q.div_new;
                s_d.rdat[`CDM_SWB_BIT]  = s_q.auto_fast_return_enable;
                s_d.rdat[`CDM_XOFF_BIT] = s_q.xoff;
                s_d.rdat[`CDM_DME_BIT]  = s_q.dme;
            end
            `CDM_IDX_STAT: begin
                s_d.rdat[`CDM_XUP_BIT] = xtal_stable_in;
            end
            default: begin
                // Unmapped reads as zero
                s_d.rdat = 32'h0000_0000;
            end
        endcase

        // Machine cycle counter on the selected source
        s_d.mc_en = mc_tick;
        if (src_tick) begin
            s_d.cnt = mc_tick ? 10'h000 : s_q.cnt + 10'h001;
        end
        // Pending ratio waits out one full machine cycle
        if (mc_tick && (s_q.pend == 2'h1)) begin
            s_d.pend = 2'h2;
        end else if (mc_tick && (s_q.pend == 2'h2)) begin
            s_d.div_act = s_q.div_new;
            s_d.pend    = 2'h0;
        end

        // Power control register
        if (pmr_wr) begin
            s_d.auto_fast_return_enable = wd[`CDM_SWB_BIT];
            s_d.dme = wd[`CDM_DME_BIT];
            // Amp may only be stopped from the ring
            if (!wd[`CDM_XOFF_BIT] || !s_q.src_xtal) begin
                s_d.xoff = wd[`CDM_XOFF_BIT];
            end
            // Only software reaches a slow ratio
            if (div_ok && (wdiv != s_q.div_new)) begin
                s_d.div_new = wdiv;
                s_d.pend    = 2'h1;
            end
        end

        // Source select, independent of the divider
        if (ext_int_flag_and_clock_source_wr) begin
            if (!wd[`CDM_SRC_BIT]) begin
                s_d.src_xtal = 1'b0;
            end else if (xtal_stable_in && !s_q.xoff) begin
                s_d.src_xtal = 1'b1;
            end
        end

        // Hardware fast return beats a same-cycle software write
        if (sb_ev) begin
            s_d.div_act = CDM_DIV_4;
            s_d.div_new = CDM_DIV_4;
            s_d.pend    = 2'h0;
            s_d.cnt     = 10'h000;
        end

        // Idle: peripherals on crystal over four, core rate ignored
        s_d.icnt  = s_q.icnt + 2'h1;
        s_d.pe_en = idle_in ? (s_q.icnt == `CDM_LIM_IDLE) : mc_tick;

        // Data moves: private RAM array, never the direct RAM
        s_d.xack    = 1'b0;
        s_d.ext_req = 1'b0;
        if (xmove_req_in && xhit) begin
            if (xmove_we_in) begin
                s_d.ram[xmove_addr_in[9:0]] = xmove_wdata_in;
            end
            s_d.xrdat = s_q.ram[xmove_addr_in[9:0]];
            s_d.xack  = 1'b1;
        end else if (xmove_req_in) begin
            s_d.ext_req = 1'b1;
            s_d.ext_we  = xmove_we_in;
            s_d.ext_adr = xmove_addr_in;
            s_d.ext_wd  = xmove_wdata_in;
        end

        // Synchronous reset to four clocks on the crystal
        if (rst_in) begin
            s_d          = '0;
            s_d.div_act  = CDM_DIV_4;
            s_d.div_new  = CDM_DIV_4;
            s_d.src_xtal = `CDM_SRC_RST;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        s_q <= s_d;
    end

    // Outputs come straight from state flops
    assign wb_dat_out       = s_q.rdat;
    assign wb_ack_out       = s_q.ack;
    assign xmove_rdata_out  = s_q.xrdat;
    assign xmove_ack_out    = s_q.xack;
    assign ext_req_out      = s_q.ext_req;
    assign ext_we_out       = s_q.ext_we;
    assign ext_addr_out     = s_q.ext_adr;
    assign ext_wdata_out    = s_q.ext_wd;
    assign mcycle_en_out    = s_q.mc_en;
    assign periph_en_out    = s_q.pe_en;
    assign xtal_amp_off_out = s_q.xoff;
    assign ring_mode_out    = ~s_q.src_xtal;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Low move with RAM on answers inside
    ram_route_a: assert property (xmove_req_in && xhit |=> xmove_ack_out && !ext_req_out)
        else $error("low move not served by RAM");
    // RAM off sends low moves out
    ram_off_a: assert property (xmove_req_in && !s_q.dme |=> ext_req_out)
        else $error("disabled RAM still served");
    // High moves leave on the port bus with their address
    ext_route_a: assert property (xmove_req_in && (xmove_addr_in > `CDM_RAM_TOP)
        |=> ext_req_out && (ext_addr_out == $past(xmove_addr_in)))
        else $error("high move not sent out");
    // Reserved code leaves the ratio alone
    rsvd_keep_a: assert property (pmr_wr && (wdiv == CDM_DIV_RSVD) && !sb_ev
        |=> $stable(s_q.div_new))
        else $error("reserved code changed ratio");
    // Slow to slow change refused
    slow_gate_a: assert property (pmr_wr && wdiv[1] && (s_q.div_act != CDM_DIV_4)
        && !sb_ev |=> s_q.div_new == $past(s_q.div_new))
        else $error("direct slow change taken");
    // Slow ratio only appears through a pending write
    hw_slow_a: assert property ((s_q.div_act != CDM_DIV_4) && ($past(s_q.div_act) == CDM_DIV_4)
        |-> $past(s_q.pend) == 2'h2)
        else $error("slow ratio without software");
    // Accepted ratio write with nothing pending and no switchback
    sequence ratio_arm_s;
        pmr_wr && div_ok && !sb_ev && (wdiv != s_q.div_new) && (s_q.pend == 2'h0);
    endsequence
    // Ratio held while the write waits out its machine cycle
    sequence ratio_wait_s;
        (s_q.pend == 2'h1) && $stable(s_q.div_act);
    endsequence
    // Accepted write does not apply on the same cycle
    delay_a: assert property (ratio_arm_s |=> ratio_wait_s)
        else $error("ratio applied at once");
    // Four-clock rate on the crystal
    rate4_a: assert property (mcycle_en_out && (s_q.div_act == CDM_DIV_4) && s_q.src_xtal
        && (s_q.pend == 2'h0) && !sb_ev |=> !mcycle_en_out[*3])
        else $error("four-clock rate wrong");
    // Amp off only from ring
    xoff_gate_a: assert property ($rose(s_q.xoff) |-> $past(!s_q.src_xtal))
        else $error("amp stopped on crystal");
    // Crystal reselect needs stable, amp on
    src_gate_a: assert property ($rose(s_q.src_xtal) |-> $past(xtal_stable_in && !s_q.xoff))
        else $error("crystal reselect not allowed");
    // Switchback returns to four clocks
    swback_a: assert property (sb_ev |=> (s_q.div_act == CDM_DIV_4) && (s_q.div_new == CDM_DIV_4))
        else $error("switchback missed");

    // Bus handshake: a request is answered next cycle, the answer lasts one
    ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus answer held too long");
    // Reset state is checked while reset is high, so the default disable is lifted
    reset_val_a: assert property (disable iff (1'b0) rst_in
        |=> (s_q.div_act == CDM_DIV_4) && s_q.src_xtal && !s_q.xoff && !s_q.dme)
        else $error("reset state wrong");
    // Outside idle the peripherals see the machine-cycle enable itself
    pe_follow_a: assert property (!idle_in |=> periph_en_out == mcycle_en_out)
        else $error("peripheral enable off the machine cycle");
    // Idle beat: a settled idle pulse, then idle held three more cycles
    sequence idle_beat_s;
        idle_in && $past(idle_in) && periph_en_out ##1 idle_in [*3];
    endsequence
    // The next peripheral pulse of the idle rate
    sequence idle_next_s;
        periph_en_out;
    endsequence
    idle_rate_a: assert property (idle_beat_s |=> idle_next_s)
        else $error("idle peripheral rate wrong");
    // A settled idle pulse is never followed at once by another
    idle_gap_a: assert property (idle_in && $past(idle_in) && periph_en_out |=> !periph_en_out)
        else $error("idle peripheral pulse too long");
    // Port bus address holds between off-chip moves
    ext_hold_a: assert property (!xmove_req_in |=> $stable(ext_addr_out))
        else $error("port bus address moved without a request");

endmodule // cdm_top

// *** rtl/cdm_regs.svh ***
// Purpose: Offsets, bit positions, resets and counts of the cycle divider
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef CDM_REGS_SVH
`define CDM_REGS_SVH
// Register indexes
`define CDM_IDX_EXT_INT_FLAG_AND_CLOCK_SOURCE   8'h91
`define CDM_IDX_PMR    8'hc4
`define CDM_IDX_STAT   8'hc5
// Power control fields
`define CDM_DIV_HI     7
`define CDM_DIV_LO     6
`define CDM_SWB_BIT    5
`define CDM_XOFF_BIT   3
`define CDM_DME_BIT    0
// Clock source fields
`define CDM_SRC_BIT    3
`define CDM_RGMD_BIT   2
// Status fields
`define CDM_XUP_BIT    4
// Reset values
`define CDM_SRC_RST    1'h1
// On-chip data RAM top address
`define CDM_RAM_TOP    16'h03ff
// Source ticks per machine cycle, minus one
`define CDM_LIM_4      10'h003
`define CDM_LIM_64     10'h03f
`define CDM_LIM_1024   10'h3ff
// Idle peripheral rate: crystal over four, minus one
`define CDM_LIM_IDLE   2'h3
`endif

// *** rtl/cdm_pkg.sv ***
// Purpose: Types of the cycle divider
// Assumes: Nothing
// Notes:   State is one packed struct
package cdm_pkg;
    // Divider field codes
    typedef enum logic [1:0] {
        CDM_DIV_RSVD = 2'h0,
        CDM_DIV_4    = 2'h1,
        CDM_DIV_64   = 2'h2,
        CDM_DIV_1024 = 2'h3
    } cdm_div_e;
    // Whole block state
    typedef struct packed {
        cdm_div_e          div_act;
        cdm_div_e          div_new;
        logic [1:0]        pend;
        logic              auto_fast_return_enable;
        logic              xoff;
        logic              dme;
        logic              src_xtal;
        logic [9:0]        cnt;
        logic [1:0]        icnt;
        logic              mc_en;
        logic              pe_en;
        logic              ack;
        logic [31:0]       rdat;
        logic [7:0]        xrdat;
        logic              xack;
        logic              ext_req;
        logic              ext_we;
        logic [15:0]       ext_adr;
        logic [7:0]        ext_wd;
        logic [1023:0][7:0] ram;
    } cdm_state_s;
endpackage

// *** dv/cdm_ext_mem.sv ***
// Purpose: External data memory seen on the multiplexed port bus
// Assumes: Request strobe is one ref clock wide
// Notes:   Capture only; the block has no off-chip read-data input
module cdm_ext_mem (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_q = 16'h0000; // Address of the latest off-chip move
    logic [7:0]  data_q = 8'h00;    // Byte of the latest off-chip write
    // Latch each off-chip move; a late or missing strobe leaves old values
    always @(posedge clk_in) begin
        if (req_in === 1'b1) begin
            last_q <= addr_in;
            if (we_in) data_q <= wdata_in;
        end
    end
endmodule // cdm_ext_mem

// *** dv/tb_cdm_top.sv ***
// Purpose: Self-checking bench of the cycle divider and data RAM map
// Assumes: Ring oscillator ticks every third ref clock
// Notes:   Outputs are read right after an edge, before that edge's updates
module tb_cdm_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] A_EX = 10'h244; // Clock source register
    localparam logic [9:0] A_PM = 10'h310; // Power control register
    localparam logic [9:0] A_ST = 10'h314; // Status register
    logic        clk = 0, rst = 1, req = 0, we = 0, xst = 1, idle = 0;
    logic        xr = 0, xwe = 0, ack, xack, ereq, ewe, mc, pe, amp, ring;
    logic [2:0]  evt = 0;            // Irq, start bit, tx load
    logic [1:0]  rdiv = 0;           // Ring tick divider
    logic [9:0]  adr = 0;
    logic [31:0] dat = 0, rdat, q;
    logic [3:0]  sel = 0;            // Byte lane selects of the bus master
    logic [15:0] xa = 0, eaddr;
    logic [7:0]  xd = 0, xrd, ewd;
    int          fail_count = 0, n_checks = 0, n;
    always #20 clk = ~clk;
    // Ring ticks keep running; only used while the ring is selected
    always @(posedge clk) rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
    cdm_top i_cdm_top (.ref_clk_in(clk), .rst_in(rst), .wb_cyc_in(req), .wb_stb_in(req),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .ring_tick_in(rdiv == 2'h0),
        .xtal_stable_in(xst), .idle_in(idle), .ext_irq_in(evt[0]), .ser_start_in(evt[1]),
        .tx_load_in(evt[2]), .xmove_req_in(xr), .xmove_we_in(xwe), .xmove_addr_in(xa),
        .xmove_wdata_in(xd), .xmove_rdata_out(xrd), .xmove_ack_out(xack),
        .ext_req_out(ereq), .ext_we_out(ewe), .ext_addr_out(eaddr), .ext_wdata_out(ewd),
        .mcycle_en_out(mc), .periph_en_out(pe), .xtal_amp_off_out(amp),
        .ring_mode_out(ring));
    cdm_ext_mem i_cdm_ext_mem (.clk_in(clk), .req_in(ereq), .we_in(ewe),
        .addr_in(eaddr), .wdata_in(ewd));
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        sel <= 4'h1;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        req <= 0;
        sel <= 4'h0;
        if (k >= 50) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] e);
        wb(0, a, 8'h00);
        chk(q, e);
    endtask
    // Interval between two machine-cycle (p=0) or peripheral (p=1) pulses
    task automatic per(input logic p, input int e);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while ((p ? pe : mc) !== 1'b1 && n < 3000);
            // Either wait running out ends the run
            if (n >= 3000) begin
                fail_count++;
                finish_test();
            end
        end
        chk(n, e);
    endtask
    // One data move; i=1 expects the on-chip RAM to answer
    task automatic mv(input logic w, input logic [15:0] a, input logic i, input logic [7:0] e);
        @(posedge clk);
        xr <= 1;
        xwe <= w;
        xa <= a;
        xd <= e;
        @(posedge clk);
        xr <= 0;
        @(posedge clk);
        chk({xack, ereq}, i ? 2'b10 : 2'b01);
        if (i && !w) chk(xrd, e);
        if (!i) chk(eaddr, a);
    endtask
    task automatic t_reset();
        rdc(A_PM, 32'h0000_0040);
        rdc(A_EX, 32'h0000_0008);
        rdc(A_ST, 32'h0000_0010);
        rdc(10'h000, 32'h0000_0000);
        per(0, 4);
        chk(ring, 0);
    endtask
    // Leaving a slow ratio still waits one machine cycle at the slow rate
    task automatic t_div();
        wb(1, A_PM, 8'h80);
        per(0, 4);
        per(0, 64);
        wb(1, A_PM, 8'hc0);
        rdc(A_PM, 32'h0000_0080);
        wb(1, A_PM, 8'h00);
        rdc(A_PM, 32'h0000_0080);
        per(0, 64);
        wb(1, A_PM, 8'h40);
        per(0, 64);
        per(0, 4);
        wb(1, A_PM, 8'hc0);
        per(0, 4);
        per(0, 1024);
        wb(1, A_PM, 8'h40);
        per(0, 1024);
        per(0, 4);
    endtask
    // Each switchback event in turn pulls a slow divider back to four
    task automatic t_swb();
        for (int i = 0; i < 3; i++) begin
            wb(1, A_PM, 8'h60);
            wb(1, A_PM, 8'ha0);
            per(0, 4);
            per(0, 64);
            @(posedge clk);
            evt <= 3'h1 << i;
            @(posedge clk);
            evt <= 3'h0;
            per(0, 4);
        end
        wb(1, A_PM, 8'h40);
    endtask
    // Ratio stays first, then the ring, then the amp; back by crystal reselect
    task automatic t_ring();
        wb(1, A_EX, 8'h00);
        rdc(A_EX, 32'h0000_0004);
        chk(ring, 1);
        per(0, 12);
        wb(1, A_PM, 8'h48);
        @(posedge clk);
        chk(amp, 1);
        wb(1, A_EX, 8'h08);
        rdc(A_EX, 32'h0000_0004);
        wb(1, A_PM, 8'h40);
        xst <= 0;
        wb(1, A_EX, 8'h08);
        rdc(A_EX, 32'h0000_0004);
        rdc(A_ST, 32'h0000_0000);
        chk(amp, 0);
        xst <= 1;
        wb(1, A_EX, 8'h08);
        rdc(A_EX, 32'h0000_0008);
        chk(ring, 0);
        wb(1, A_PM, 8'h48);
        rdc(A_PM, 32'h0000_0040);
    endtask
    task automatic t_ram();
        wb(1, A_PM, 8'h41);
        mv(1, 16'h03ff, 1, 8'h5a);
        mv(0, 16'h03ff, 1, 8'h5a);
        mv(1, 16'h0400, 0, 8'ha5);
        @(posedge clk);
        chk(i_cdm_ext_mem.data_q, 8'ha5);
        wb(1, A_PM, 8'h40);
        mv(0, 16'h0000, 0, 8'h00);
    endtask
    // Idle keeps peripherals at crystal over four while the core runs slow
    task automatic t_idle();
        wb(1, A_PM, 8'h80);
        per(0, 4);
        idle <= 1;
        per(1, 4);
        idle <= 0;
        per(1, 64);
        wb(1, A_PM, 8'h40);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        t_reset();
        t_div();
        t_swb();
        t_ring();
        t_ram();
        t_idle();
        finish_test();
    end
endmodule // tb_cdm_top
